// [rtl/dcac_channel.sv]
// one dma channel: enable, memory pointer, memory limit, peripheral pointer
// assumes packet completion pulses come from the flow-controlling peripheral on sys_clk_in
`timescale 1ns/1ns
`default_nettype none
`include "dcac_defines.svh"

module dcac_channel #(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [31:0]       rdata_out,
	input  wire logic              global_enable_in,
	input  wire logic [2:0]        packet_size_in,
	input  wire logic              mem_inc_in,
	input  wire logic              per_inc_in,
	input  wire logic              packet_done_in,
	output logic                   active_out,
	output logic                   done_out,
	output logic      [31:0]       mem_target_out,
	output logic      [31:0]       master_addr_out
);
	logic                  channel_enable;
	logic [31:0]           memory_pointer;
	logic [31:0]           memory_limit;
	logic [31:0]           peripheral_pointer;
	dcac_pkg::dcac_state_e state;
	logic                  running;
	logic                  step;
	logic                  at_limit;
	logic [31:0]           size_ext;
	logic                  w_en;
	logic                  w_mp;
	logic                  w_ml;
	logic                  w_pp;

	// both enables required, global clear stops all
	// combined enable
	assign running  = channel_enable && global_enable_in;
	assign size_ext = {29'h0000_0000, packet_size_in};
	assign step     = running && (state == dcac_pkg::DCAC_RUN) && packet_done_in;
	assign at_limit = mem_inc_in && (memory_pointer == memory_limit);

	assign w_en = wr_in && (addr_in == ADDR_W'(`DCAC_OFS_ENABLE));
	assign w_mp = wr_in && (addr_in == ADDR_W'(`DCAC_OFS_MEM_PTR));
	assign w_ml = wr_in && (addr_in == ADDR_W'(`DCAC_OFS_MEM_LIM));
	assign w_pp = wr_in && (addr_in == ADDR_W'(`DCAC_OFS_PER_PTR));

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			channel_enable <= 1'b0;
		end else if (w_en) begin
			channel_enable <= wdata_in[`DCAC_BIT_ENABLE];
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= dcac_pkg::DCAC_IDLE;
		end else begin
			case (state)
				dcac_pkg::DCAC_IDLE: begin
					if (running && !at_limit) begin
						state <= dcac_pkg::DCAC_RUN;
					end
				end
				dcac_pkg::DCAC_RUN: begin
					if (!running) begin
						state <= dcac_pkg::DCAC_IDLE;
					end else if (at_limit) begin
						state <= dcac_pkg::DCAC_DONE;
					end
				end
				dcac_pkg::DCAC_DONE: begin
					if (!running || w_mp || w_ml) begin
						state <= dcac_pkg::DCAC_IDLE;
					end
				end
				default: begin
					state <= dcac_pkg::DCAC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			memory_pointer <= `DCAC_RST_WORD;
		end else if (w_mp) begin
			memory_pointer <= wdata_in;
		end else if (step && mem_inc_in && !at_limit) begin
			memory_pointer <= memory_pointer + size_ext;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			memory_limit <= `DCAC_RST_WORD;
		end else if (w_ml) begin
			memory_limit <= wdata_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			peripheral_pointer <= `DCAC_RST_WORD;
		end else if (w_pp) begin
			peripheral_pointer <= wdata_in;
		end else if (step && per_inc_in && !at_limit) begin
			peripheral_pointer <= peripheral_pointer + size_ext;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= `DCAC_RST_WORD;
		end else if (rd_in) begin
			if (addr_in == ADDR_W'(`DCAC_OFS_ENABLE)) begin
				rdata_out <= {31'h0000_0000, channel_enable};
			end else if (addr_in == ADDR_W'(`DCAC_OFS_MEM_PTR)) begin
				rdata_out <= memory_pointer;
			end else if (addr_in == ADDR_W'(`DCAC_OFS_MEM_LIM)) begin
				rdata_out <= memory_limit;
			end else if (addr_in == ADDR_W'(`DCAC_OFS_PER_PTR)) begin
				rdata_out <= peripheral_pointer;
			end else if (addr_in == ADDR_W'(`DCAC_OFS_STATUS)) begin
				rdata_out <= {30'h0000_0000, state == dcac_pkg::DCAC_DONE,
					state == dcac_pkg::DCAC_RUN};
			end else begin
				rdata_out <= `DCAC_RST_WORD;
			end
		end else begin
			rdata_out <= `DCAC_RST_WORD;
		end
	end

	assign active_out = (state == dcac_pkg::DCAC_RUN) && running;
	assign done_out   = (state == dcac_pkg::DCAC_DONE);
	assign mem_target_out  = memory_pointer;
	assign master_addr_out = peripheral_pointer;
endmodule

`default_nettype wire

// [rtl/dcac_defines.svh]
// register offsets, field positions and reset values for the dma channel address block
// assumes the register port carries byte addresses with 32-bit data
//
// Functional notes
// - channel runs only with both enables set
// - memory pointer advances by packet size
// - memory side is the slave target
// - stop and flag done at memory limit when memory increments
// - device pointer addresses the flow master
// - device pointer advances by packet size
// - global enable gates every channel
`ifndef DCAC_DEFINES_SVH
`define DCAC_DEFINES_SVH

`define DCAC_OFS_ENABLE   8'h00
`define DCAC_OFS_MEM_PTR  8'h04
`define DCAC_OFS_MEM_LIM  8'h08
`define DCAC_OFS_PER_PTR  8'h0c
`define DCAC_OFS_STATUS   8'h10
`define DCAC_BIT_ENABLE   0
`define DCAC_BIT_ACTIVE   0
`define DCAC_BIT_DONE     1
`define DCAC_RST_WORD     32'h0000_0000

`endif

// [rtl/dcac_pkg.sv]
// types for the dma channel address block
// assumes the defines header is compiled alongside
package dcac_pkg;
	typedef enum logic [1:0] {
		DCAC_IDLE = 2'b00,
		DCAC_RUN  = 2'b01,
		DCAC_DONE = 2'b10
	} dcac_state_e;
endpackage

// [sim/dcac_channel_monitor.sv]
// assertions on the ports of one dma channel
// assumes one clock domain, bound to every dcac_channel
`timescale 1ns/1ns
`default_nettype none
`include "dcac_defines.svh"
module dcac_channel_monitor (
	input wire logic        sys_clk_in,       rst_in,
	input wire logic [7:0]  addr_in,
	input wire logic        wr_in,            rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        global_enable_in, mem_inc_in, per_inc_in, packet_done_in,
	input wire logic [2:0]  packet_size_in,
	input wire logic        active_out,       done_out,
	input wire logic [31:0] mem_target_out,   master_addr_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence step_s; active_out && packet_done_in && !wr_in; endsequence
	sequence still_s; !(active_out && packet_done_in) && !wr_in; endsequence
	chk_act_enables: assert property (active_out |-> global_enable_in && !done_out)
		else $error("active without enables");
	chk_mem_advance: assert property (step_s ##0 mem_inc_in |=>
		mem_target_out == $past(mem_target_out) + 32'($past(packet_size_in))) else $error("mem step");
	chk_mem_hold: assert property (still_s |=> $stable(mem_target_out))
		else $error("mem pointer moved");
	chk_per_advance: assert property (step_s ##0 per_inc_in |=>
		master_addr_out == $past(master_addr_out) + 32'($past(packet_size_in))) else $error("dev step");
	chk_per_hold: assert property (still_s |=> $stable(master_addr_out))
		else $error("device pointer moved");
	chk_done_mem_inc: assert property ($rose(done_out) |-> $past(mem_inc_in))
		else $error("done without increment");
	chk_rd_idle: assert property (!rd_in |=> rdata_out == 32'h0) else $error("stray read data");
	chk_rd_mem_ptr: assert property (rd_in && addr_in == `DCAC_OFS_MEM_PTR |=>
		rdata_out == $past(mem_target_out)) else $error("read of memory pointer");
endmodule
bind dcac_channel dcac_channel_monitor dcac_channel_monitor_inst (.sys_clk_in(sys_clk_in),
	.rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.global_enable_in(global_enable_in), .mem_inc_in(mem_inc_in), .per_inc_in(per_inc_in),
	.packet_done_in(packet_done_in), .packet_size_in(packet_size_in), .active_out(active_out),
	.done_out(done_out), .mem_target_out(mem_target_out), .master_addr_out(master_addr_out));
`default_nettype wire

// [sim/dcac_channel_tb.sv]
// register tests and packet runs for one dma channel
// assumes the flow model as the far side
`timescale 1ns/1ns
`default_nettype none
module dcac_channel_tb;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, glb = 0, pinc = 1, pd, act, done;
	logic [7:0]  addr = 8'h0;
	logic [2:0]  size = 3'h4, sz [3] = '{3'h1, 3'h2, 3'h4};
	logic [3:0]  gap = 4'h4;
	logic [31:0] wdata = 32'h0, rdata, mtgt, madr;
	int          num_errors = 0, check_count = 0;
	always #20 clk = ~clk;
	dcac_channel dcac_channel_inst (.sys_clk_in(clk), .rst_in(rst), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .global_enable_in(glb),
		.packet_size_in(size), .mem_inc_in(1'b1), .per_inc_in(pinc), .packet_done_in(pd),
		.active_out(act), .done_out(done), .mem_target_out(mtgt), .master_addr_out(madr));
	dcac_flow_model dcac_flow_model_inst (.sys_clk_in(clk), .rst_in(rst), .active_in(act),
		.gap_in(gap), .packet_done_out(pd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 6; i++) begin
			acc(0, 8'(4 * i + 4 * (i / 5)), 32'h0);
			chk(rdata, 32'h0);
		end
		$display("reset value test done");
		acc(1, 8'h00, 32'h1);
		chk(32'(act), 32'h0);
		glb <= 1;
		foreach (sz[i]) begin
			acc(1, 8'h00, 32'h0);
			size <= sz[i];
			gap <= 4'(sz[i]);
			pinc <= i != 1;
			acc(1, 8'h04, 32'h100);
			acc(1, 8'h08, 32'h100 + 32'(sz[i]) * 8);
			acc(1, 8'h0c, 32'h2000);
			acc(1, 8'h00, 32'h1);
			repeat (100) if (!done) @(posedge clk);
			#1 chk(32'(done), 32'h1);
			chk(mtgt, 32'h100 + 32'(sz[i]) * 8);
			chk(madr, 32'h2000 + (i != 1 ? 32'(sz[i]) * 8 : 32'h0));
			acc(0, 8'h10, 32'h0);
			chk(rdata, 32'h2);
			$display("size test %0d done", sz[i]);
		end
		gap <= 4'hf;
		acc(1, 8'h04, 32'h0);
		@(posedge clk);
		#1 chk(32'(act), 32'h1);
		glb <= 0;
		acc(0, 8'h04, 32'h0);
		chk(32'(act), 32'h0);
		chk(rdata, 32'h0);
		chk(mtgt, 32'h0);
		$display("global disable test done");
		summarize();
	end
	initial begin
		#400000;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire

// [sim/dcac_flow_model.sv]
// flow-controlling peripheral: one packet pulse every gap_in + 1 cycles
// assumes the channel's active flag on the same clock
`timescale 1ns/1ns
`default_nettype none
module dcac_flow_model (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       active_in,
	input  wire logic [3:0] gap_in,
	output logic            packet_done_out
);
	logic [3:0] cnt;
	assign packet_done_out = active_in && cnt == gap_in;
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) cnt <= 4'h0;
		else cnt <= (packet_done_out || !active_in) ? 4'h0 : cnt + 4'h1;
	end
endmodule
`default_nettype wire
